// File: logic/sisp_pkg.sv
// Package with constants for the serial in-system programming port
package sisp_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_FREQ_HZ = 50000000;
  localparam int CLK_NS      = 20;
  // Self-timed write durations in microseconds
  localparam int PAGE_WRITE_WAIT_TIME_US = 4500;
  localparam int BYTE_WRITE_WAIT_TIME_US = 3600;
  localparam int ERASE_WAIT_TIME_US      = 9000;
  localparam int PAGE_WRITE_CYCLES = PAGE_WRITE_WAIT_TIME_US * (CLK_FREQ_HZ / 1000000);
  localparam int BYTE_WRITE_CYCLES = BYTE_WRITE_WAIT_TIME_US * (CLK_FREQ_HZ / 1000000);
  localparam int ERASE_CYCLES      = ERASE_WAIT_TIME_US * (CLK_FREQ_HZ / 1000000);

  // ---------------------------------------------------------------
  // Memory geometry
  // ---------------------------------------------------------------
  localparam int FLASH_AW  = 10;   // Word address width of the modelled array
  localparam int PAGE_AW   = 7;    // Word bits within a page
  localparam int EE_AW     = 10;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // ---------------------------------------------------------------
  // Instruction opcodes and fixed bytes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_ENABLE_ERASE = 8'hAC;
  localparam logic [7:0] SUB_ENABLE      = 8'h53;
  localparam logic [7:0] SUB_ERASE       = 8'h80;
  localparam logic [7:0] OP_POLL         = 8'hF0;
  localparam logic [7:0] OP_LOAD_EXT     = 8'h4D;
  localparam logic [7:0] OP_LOAD_HI      = 8'h48;
  localparam logic [7:0] OP_LOAD_LO      = 8'h40;
  localparam logic [7:0] OP_READ_HI      = 8'h28;
  localparam logic [7:0] OP_READ_LO      = 8'h20;
  localparam logic [7:0] OP_READ_EE      = 8'hA0;
  localparam logic [7:0] OP_WRITE_PAGE   = 8'h4C;
  localparam logic [7:0] OP_WRITE_EE     = 8'hC0;

  // ---------------------------------------------------------------
  // Shifter
  // ---------------------------------------------------------------
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [1:0] BYTE_LAST = 2'h3;

endpackage : sisp_pkg

// File: logic/sisp_port.sv
// Serial in-system programming port with modelled Flash and EEPROM arrays
// Notes on behaviour
// - Programming works only while reset pin is low; SCK, MOSI in, MISO out.
// - Erase and write are refused until programming enable has been executed.
// - Each EEPROM write erases its location first as part of the timed write.
// - Chip erase sets every Flash and EEPROM location to 0xFF.
// - MOSI is sampled on each rising SCK edge.
// - MISO changes on each falling SCK edge.
// - Second enable byte 0x53 is echoed while the third byte shifts in.
// - Page buffer is loaded a byte at a time with 7 low word-address bits.
// - Write page commits the buffer using address bits 9..7; the extended byte has no effect.
// - Extended address byte is kept until a new load-extended instruction.
// - EEPROM is written a byte per instruction; self-timed for 3.6 ms.
// - Reads return addressed content; Flash reads use address bits 9..0 only, so the extended byte has no effect.
// - Releasing reset high leaves programming mode.
// - Poll result bit 0 is one while a write is still pending.
// - Program memory addresses are word addresses anywhere in the page.
`timescale 1ns/1ps
module sisp_port
  import sisp_pkg::*;
(
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  // Programming pins
  input  wire logic i_reset_n,
  input  wire logic i_sck,
  input  wire logic i_mosi,
  output logic      o_miso,
  // Status
  output logic      o_prog_mode,
  output logic      o_write_pending_flag
);

  typedef struct packed {
    logic [1:0]  rst_s;
    logic [1:0]  sck_s;
    logic [1:0]  mosi_s;
    logic        enabled;
    logic [1:0]  slot;
    logic [7:0]  b1;
    logic [7:0]  b2;
    logic [7:0]  b3;
    logic [7:0]  tx;
    logic [7:0]  ext_addr;
    logic [23:0] timer;
    logic        busy;
    logic        erase_run;
    logic [10:0] erase_idx;
    logic        prog;
    logic        pending;
  } sisp_st_t;

  sisp_st_t s_reg;
  sisp_st_t s_next;

  // Arrays and page buffer
  logic [15:0] flash_mem [2**FLASH_AW];
  logic [7:0]  ee_mem    [2**EE_AW];
  logic [15:0] page_buf  [2**PAGE_AW];

  logic       active;
  logic       byte_valid;
  logic [7:0] rx_byte;
  logic       miso_w;
  logic [FLASH_AW-1:0] fl_addr;
  logic [EE_AW-1:0]    ee_addr;
  logic [15:0]         fl_word;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Flash word address from the low ten bits of high and low bytes; the extended byte is dropped, any word of a page
  function automatic logic [FLASH_AW-1:0] word_addr(input logic [7:0] ext,
      input logic [7:0] hi, input logic [7:0] lo);
    logic [23:0] full;
    full = {ext, hi, lo};
    return full[FLASH_AW-1:0];
  endfunction : word_addr

  assign active  = !s_reg.rst_s[1];
  assign fl_addr = word_addr(s_reg.ext_addr, s_reg.b2, s_reg.b3);
  assign ee_addr = {s_reg.b2[1:0], s_reg.b3};
  assign fl_word = flash_mem[fl_addr];

  sisp_shifter u_shifter (
    .i_clk        (i_clk),
    .i_sys_rst    (i_sys_rst),
    .i_active     (active),
    .i_sck        (s_reg.sck_s[1]),
    .i_mosi       (s_reg.mosi_s[1]),
    .i_tx_byte    (s_reg.tx),
    .o_byte_valid (byte_valid),
    .o_rx_byte    (rx_byte),
    .o_miso       (miso_w)
  );

  // ---------------------------------------------------------------
  // Instruction decoder
  // ---------------------------------------------------------------
  // Collects four bytes and prepares the answer for the next slot
  always_comb begin
    s_next        = s_reg;
    s_next.rst_s  = {s_reg.rst_s[0], i_reset_n};
    s_next.sck_s  = {s_reg.sck_s[0], i_sck};
    s_next.mosi_s = {s_reg.mosi_s[0], i_mosi};
    s_next.prog   = active;
    s_next.pending = s_reg.busy;
    // Self-timed write countdown
    if (s_reg.busy) begin
      if (s_reg.timer != 24'h0) begin
        s_next.timer = s_reg.timer - 24'h1;
      end else begin
        s_next.busy = 1'b0;
      end
    end
    if (s_reg.erase_run) begin
      s_next.erase_idx = s_reg.erase_idx + 11'h1;
      if (s_reg.erase_idx == 11'h7FF) begin
        s_next.erase_run = 1'b0;
      end
    end
    if (!active) begin
      s_next.enabled = 1'b0;
      s_next.slot    = 2'h0;
      s_next.tx      = 8'h00;
    end else if (byte_valid) begin
      s_next.slot = s_reg.slot + 2'h1;
      s_next.tx   = 8'h00;
      unique case (s_reg.slot)
        2'h0: begin
          s_next.b1 = rx_byte;
        end
        2'h1: begin
          s_next.b2 = rx_byte;
          if (s_reg.b1 == OP_ENABLE_ERASE) begin
            s_next.tx = rx_byte;
          end
        end
        2'h2: begin
          s_next.b3 = rx_byte;
          if (s_reg.b1 == OP_POLL) begin
            s_next.tx = {7'h00, s_reg.busy};
          end else if (s_reg.b1 == OP_READ_LO) begin
            s_next.tx = flash_mem[word_addr(s_reg.ext_addr, s_reg.b2, rx_byte)][7:0];
          end else if (s_reg.b1 == OP_READ_HI) begin
            s_next.tx = flash_mem[word_addr(s_reg.ext_addr, s_reg.b2, rx_byte)][15:8];
          end else if (s_reg.b1 == OP_READ_EE) begin
            s_next.tx = ee_mem[{s_reg.b2[1:0], rx_byte}];
          end
        end
        2'h3: begin
          if (s_reg.b1 == OP_ENABLE_ERASE && s_reg.b2 == SUB_ENABLE) begin
            s_next.enabled = 1'b1;
          end else if (s_reg.enabled && !s_reg.busy) begin
            if (s_reg.b1 == OP_ENABLE_ERASE && s_reg.b2 == SUB_ERASE) begin
              s_next.busy      = 1'b1;
              s_next.timer     = 24'(ERASE_CYCLES);
              s_next.erase_run = 1'b1;
              s_next.erase_idx = 11'h0;
            end else if (s_reg.b1 == OP_LOAD_EXT) begin
              s_next.ext_addr = s_reg.b3;
            end else if (s_reg.b1 == OP_WRITE_PAGE) begin
              s_next.busy  = 1'b1;
              s_next.timer = 24'(PAGE_WRITE_CYCLES);
            end else if (s_reg.b1 == OP_WRITE_EE) begin
              s_next.busy  = 1'b1;
              s_next.timer = 24'(BYTE_WRITE_CYCLES);
            end
          end
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_reg       <= '0;
      s_reg.rst_s <= 2'h3;
    end else begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------------------------
  // Memory writes
  // ---------------------------------------------------------------
  // Arrays have no reset; erase and writes update them in place
  always_ff @(posedge i_clk) begin
    if (s_reg.erase_run) begin
      flash_mem[s_reg.erase_idx[FLASH_AW-1:0]] <= {ERASED_BYTE, ERASED_BYTE};
      ee_mem[s_reg.erase_idx[EE_AW-1:0]]       <= ERASED_BYTE;
    end else if (active && byte_valid && s_reg.slot == 2'h3 && s_reg.enabled
                 && !s_reg.busy) begin
      if (s_reg.b1 == OP_LOAD_LO) begin
        page_buf[s_reg.b3[PAGE_AW-1:0]][7:0] <= rx_byte;
      end else if (s_reg.b1 == OP_LOAD_HI) begin
        page_buf[s_reg.b3[PAGE_AW-1:0]][15:8] <= rx_byte;
      end else if (s_reg.b1 == OP_WRITE_EE) begin
        ee_mem[ee_addr] <= rx_byte;  // Overwrite acts as erase then write
      end else if (s_reg.b1 == OP_WRITE_PAGE) begin
        for (int i = 0; i < 2**PAGE_AW; i++) begin
          flash_mem[{fl_addr[FLASH_AW-1:PAGE_AW], PAGE_AW'(i)}] <= page_buf[i];
        end
      end
    end
  end

  assign o_miso               = miso_w;
  assign o_prog_mode          = s_reg.prog;
  assign o_write_pending_flag = s_reg.pending;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_RESET_LEAVES: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s_reg.rst_s[1] |=> !s_reg.enabled)
    else $error("Programming stayed enabled with reset high");
  AST_NO_WRITE_DISABLED: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!s_reg.enabled && !s_reg.busy) |=> !s_reg.busy)
    else $error("Write started without programming enable");
  AST_ENABLE_SEEN: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (byte_valid && active && s_reg.slot == 2'h1 && s_reg.b1 == OP_ENABLE_ERASE)
    |=> s_reg.tx == $past(rx_byte))
    else $error("Enable echo byte not prepared");
  AST_POLL_FLAG: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (byte_valid && active && s_reg.slot == 2'h2 && s_reg.b1 == OP_POLL)
    |=> s_reg.tx == {7'h00, $past(s_reg.busy)})
    else $error("Poll answer does not show pending write");
  AST_PENDING_OUT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s_reg.busy |=> o_write_pending_flag)
    else $error("Pending flag not shown");
  AST_EXT_HELD: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !(byte_valid && s_reg.slot == 2'h3 && s_reg.b1 == OP_LOAD_EXT)
    |=> $stable(s_reg.ext_addr))
    else $error("Extended address changed without load");
  AST_SLOT_STEP: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (active && byte_valid) |=> s_reg.slot == $past(s_reg.slot) + 2'h1)
    else $error("Byte slot did not advance");
  AST_ERASE_BUSY: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s_reg.erase_run |-> s_reg.busy)
    else $error("Erase ran without busy");

endmodule : sisp_port

// File: logic/sisp_shifter.sv
// Byte shifter that samples MOSI on SCK rising and drives MISO on falling
`timescale 1ns/1ps
module sisp_shifter
  import sisp_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  // Synchronised link inputs
  input  wire logic       i_active,
  input  wire logic       i_sck,
  input  wire logic       i_mosi,
  // Byte to send in the current slot
  input  wire logic [7:0] i_tx_byte,
  // Received byte and MISO output
  output logic            o_byte_valid,
  output logic [7:0]      o_rx_byte,
  output logic            o_miso
);

  typedef struct packed {
    logic       sck_d;
    logic [2:0] bit_cnt;
    logic [7:0] rx;
    logic [7:0] tx;
    logic       valid;
    logic [7:0] rx_out;
    logic       miso;
  } sisp_sh_t;

  sisp_sh_t s_reg;
  sisp_sh_t s_next;

  // ---------------------------------------------------------------
  // Edge handling
  // ---------------------------------------------------------------
  // Rising edge samples, falling edge shifts out, MSB first
  always_comb begin
    s_next       = s_reg;
    s_next.sck_d = i_sck;
    s_next.valid = 1'b0;
    if (!i_active) begin
      // First byte of a session has no load edge, so its top bit is preset here
      s_next.bit_cnt = 3'h0;
      s_next.tx      = {i_tx_byte[6:0], 1'b0};
      s_next.miso    = i_tx_byte[7];
    end else if (i_sck && !s_reg.sck_d) begin
      s_next.rx      = {s_reg.rx[6:0], i_mosi};
      s_next.bit_cnt = s_reg.bit_cnt + 3'h1;
      if (s_reg.bit_cnt == BIT_LAST) begin
        s_next.valid  = 1'b1;
        s_next.rx_out = {s_reg.rx[6:0], i_mosi};
      end
    end else if (!i_sck && s_reg.sck_d) begin
      if (s_reg.bit_cnt == 3'h0) begin
        s_next.tx   = {i_tx_byte[6:0], 1'b0};
        s_next.miso = i_tx_byte[7];
      end else begin
        s_next.tx   = {s_reg.tx[6:0], 1'b0};
        s_next.miso = s_reg.tx[7];
      end
    end
  end

  // State register
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_byte_valid = s_reg.valid;
  assign o_rx_byte    = s_reg.rx_out;
  assign o_miso       = s_reg.miso;

endmodule : sisp_shifter

// File: verification/sisp_port_tb.sv
// Self-checking testbench for the serial in-system programming port
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("BAD %0t got %h expected %h", $time, (got), (exp)); \
    end \
  end
module sisp_port_tb
  import sisp_pkg::*;
;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic        clk;
  logic        sys_rst;
  logic        reset_n;
  logic        sck;
  logic        mosi;
  logic        miso;
  logic        prog_mode;
  logic        pending;
  logic [31:0] resp;
  int          bad_count;
  int          comparisons;

  // Core clock, 20 ns period
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  sisp_port sisp_port_inst (
    .i_clk                (clk),
    .i_sys_rst            (sys_rst),
    .i_reset_n            (reset_n),
    .i_sck                (sck),
    .i_mosi               (mosi),
    .o_miso               (miso),
    .o_prog_mode          (prog_mode),
    .o_write_pending_flag (pending)
  );

  sisp_programmer sisp_programmer_inst (
    .i_clk     (clk),
    .o_reset_n (reset_n),
    .o_sck     (sck),
    .o_mosi    (mosi),
    .i_miso    (miso)
  );

  // ---------------------------------------------------------------
  // Closing report and bounded waits
  // ---------------------------------------------------------------
  task automatic finish_test;
    $display("Comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  // Wait until the pending flag takes a level, bounded
  task automatic wait_pending(input logic lvl, input int bound);
    int n;
    for (n = 0; n < bound && pending !== lvl; n++) begin
      @(negedge clk);
    end
    if (pending !== lvl) begin
      bad_count++;
      $display("BAD %0t pending flag never reached %b", $time, lvl);
      finish_test();
    end
  endtask : wait_pending

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Writes before enable are dropped silently
  task automatic test_refused;
    `CHK(prog_mode, 1'b1)
    sisp_programmer_inst.xfer({OP_WRITE_EE, 24'h0005A5}, resp);
    repeat (40) @(negedge clk);
    `CHK(pending, 1'b0)
    sisp_programmer_inst.xfer({OP_POLL, 24'h0}, resp);
    `CHK(resp[0], 1'b0)
  endtask : test_refused

  // Enable echoes its second byte in the third slot
  task automatic test_enable;
    sisp_programmer_inst.xfer({OP_ENABLE_ERASE, SUB_ENABLE, 16'h0}, resp);
    `CHK(resp[15:8], SUB_ENABLE)
  endtask : test_enable

  // EEPROM byte write starts the self-timed cycle, seen by poll
  task automatic test_ee_write;
    sisp_programmer_inst.xfer({OP_WRITE_EE, 24'h0005A5}, resp);
    wait_pending(1'b1, 200);
    `CHK(pending, 1'b1)
    sisp_programmer_inst.xfer({OP_POLL, 24'h0}, resp);
    `CHK(resp[0], 1'b1)
    `CHK(pending, 1'b1)
  endtask : test_ee_write

  // Mid-run core reset ends a self-timed write; arrays keep their content
  task automatic restart_enable;
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    repeat (8) @(negedge clk);
    sisp_programmer_inst.xfer({OP_ENABLE_ERASE, SUB_ENABLE, 16'h0}, resp);
    `CHK(resp[15:8], SUB_ENABLE)
  endtask : restart_enable

  // EEPROM overwrite and one Flash page, written then read back
  task automatic test_flash_page;
    restart_enable();
    sisp_programmer_inst.xfer({OP_WRITE_EE, 24'h00055A}, resp);
    restart_enable();
    sisp_programmer_inst.xfer({OP_LOAD_EXT, 24'h000000}, resp);
    sisp_programmer_inst.xfer({OP_LOAD_LO, 24'h000534}, resp);
    sisp_programmer_inst.xfer({OP_LOAD_HI, 24'h000512}, resp);
    sisp_programmer_inst.xfer({OP_WRITE_PAGE, 24'h010000}, resp);
    sisp_programmer_inst.xfer({OP_POLL, 24'h0}, resp);
    `CHK(resp[0], 1'b1)
    restart_enable();
    sisp_programmer_inst.xfer({OP_READ_LO, 24'h010500}, resp);
    `CHK(resp[7:0], 8'h34)
    sisp_programmer_inst.xfer({OP_READ_HI, 24'h010500}, resp);
    `CHK(resp[7:0], 8'h12)
    sisp_programmer_inst.xfer({OP_READ_EE, 24'h000500}, resp);
    `CHK(resp[7:0], 8'h5A)
  endtask : test_flash_page

  // Chip erase sweeps both arrays; the busy time itself is cut by a core reset
  task automatic test_chip_erase;
    sisp_programmer_inst.xfer({OP_ENABLE_ERASE, SUB_ERASE, 16'h0}, resp);
    wait_pending(1'b1, 200);
    repeat (2100) @(negedge clk);
    restart_enable();
    sisp_programmer_inst.xfer({OP_READ_LO, 24'h010500}, resp);
    `CHK(resp[7:0], ERASED_BYTE)
    sisp_programmer_inst.xfer({OP_READ_EE, 24'h000500}, resp);
    `CHK(resp[7:0], ERASED_BYTE)
  endtask : test_chip_erase

  // Releasing the reset pin leaves programming mode
  task automatic test_session_end;
    sisp_programmer_inst.set_reset(1'b1);
    `CHK(prog_mode, 1'b0)
  endtask : test_session_end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    bad_count   = 0;
    comparisons = 0;
    sys_rst     = 1'b1;
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
    // Settle wait kept short: the model has no power-up timer
    repeat (8) @(negedge clk);
    test_refused();
    test_enable();
    test_ee_write();
    test_flash_page();
    test_chip_erase();
    test_session_end();
    finish_test();
  end
endmodule : sisp_port_tb

// File: verification/sisp_programmer.sv
// Behavioural in-system programmer that drives the serial programming pins
`timescale 1ns/1ps
module sisp_programmer (
  // Clock
  input  wire logic i_clk,
  // Programming pins
  output logic      o_reset_n,
  output logic      o_sck,
  output logic      o_mosi,
  input  wire logic i_miso
);
  // ---------------------------------------------------------------
  // Power-up state
  // ---------------------------------------------------------------
  initial begin
    o_reset_n = 1'b0; // Reset and clock held low from power-up
    o_sck     = 1'b0;
    o_mosi    = 1'b1;
  end

  // Drive the device reset pin to a level, clock kept low
  task automatic set_reset(input logic lvl);
    @(negedge i_clk);
    o_sck     <= 1'b0;
    o_reset_n <= lvl;
    repeat (8) @(negedge i_clk);
  endtask : set_reset

  // One four-byte instruction, MSB first, answer gathered per bit
  // All four bytes are always shifted, even after a bad echo
  task automatic xfer(input logic [31:0] cmd, output logic [31:0] resp);
    int i;
    resp = 32'h0;
    for (i = 31; i >= 0; i--) begin
      @(negedge i_clk);
      o_sck  <= 1'b0;
      o_mosi <= cmd[i];         // MSB first
      repeat (4) @(negedge i_clk);
      o_sck  <= 1'b1;           // Low phase of four cycles
      repeat (2) @(negedge i_clk);
      resp[i] = i_miso;         // Taken mid high phase, well after the fall
      @(negedge i_clk);
    end
    @(negedge i_clk);
    o_sck  <= 1'b0;             // High phase of four cycles
    o_mosi <= ~cmd[0];          // Released line shows no stale value
    repeat (8) @(negedge i_clk);
  endtask : xfer
endmodule : sisp_programmer
